//--- spso_bus_model.sv
// Memory and I/O bus partner model for the execution block
`timescale 1ns/1ps
`default_nettype none
module spso_bus_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [1:0] ackDelay,
    input wire logic memReq,
    input wire logic memWe,
    input wire logic memWide,
    input wire logic [15:0] memSeg,
    input wire logic [15:0] memOff,
    input wire logic [15:0] memWdata,
    input wire logic ioReq,
    input wire logic [15:0] ioPort,
    input wire logic [15:0] ioWdata,
    output logic memAck,
    output logic [15:0] memRdata,
    output logic ioAck
);
    logic [7:0] mem [0:255];
    logic [1:0] memWait;
    logic [1:0] ioWait;
    logic [15:0] lastSeg;
    logic [15:0] lastPort;
    logic [15:0] lastIo;
    int ioCount;
    wire logic [7:0] lo = memOff[7:0];
    wire logic [7:0] hi = memOff[7:0] + 8'h01;
    // Read data toggles outside a read ack so a stale word never looks valid
    always @(posedge clk) begin
        if (!rst_n) begin
            memAck <= 1'b0;
            ioAck <= 1'b0;
            memWait <= 2'h0;
            ioWait <= 2'h0;
            ioCount <= 0;
            memRdata <= 16'h0000;
        end else begin
            memAck <= 1'b0;
            ioAck <= 1'b0;
            memRdata <= ~memRdata;
            if (memReq && !memAck) begin
                if (memWait == ackDelay) begin
                    memAck <= 1'b1;
                    memWait <= 2'h0;
                    lastSeg <= memSeg;
                    if (memWe) begin
                        mem[lo] <= memWdata[7:0];
                        if (memWide) mem[hi] <= memWdata[15:8];
                    end else begin
                        memRdata <= memWide ? {mem[hi], mem[lo]} : {8'h00, mem[lo]};
                    end
                end else memWait <= memWait + 2'h1;
            end
            if (ioReq && !ioAck) begin
                if (ioWait == ackDelay) begin
                    ioAck <= 1'b1;
                    ioWait <= 2'h0;
                    lastPort <= ioPort;
                    lastIo <= ioWdata;
                    ioCount <= ioCount + 1;
                end else ioWait <= ioWait + 2'h1;
            end
        end
    end
endmodule : spso_bus_model
`default_nettype wire

//--- spso_exec.sv
// Execution sequencer for string port output, pops and push
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module spso_exec (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cmdValid,
    input wire logic [2:0] cmdOp,
    input wire logic cmdWide,
    input wire logic cmdRep,
    input wire logic cmdSegOvr,
    input wire logic [1:0] cmdSegSel,
    input wire logic [1:0] cmdKind,
    input wire logic [2:0] cmdIdx,
    input wire logic [15:0] cmdEaOff,
    input wire logic ldValid,
    input wire logic [3:0] ldSel,
    input wire logic [15:0] ldData,
    input wire logic memAck,
    input wire logic [15:0] memRdata,
    input wire logic ioAck,
    output logic cmdReady,
    output logic cmdDone,
    output logic cmdIllegal,
    output logic memReq,
    output logic memWe,
    output logic memWide,
    output logic [15:0] memSeg,
    output logic [15:0] memOff,
    output logic [15:0] memWdata,
    output logic ioReq,
    output logic ioWide,
    output logic [15:0] ioPort,
    output logic [15:0] ioWdata,
    output logic [127:0] gprBank,
    output logic [63:0] segBank,
    output logic [15:0] flagWord
);
    // ------------------------------------------------------------------
    // State and latched command
    // ------------------------------------------------------------------
    spso_pkg::spso_state_e state_reg, state_next;
    logic [7:0][15:0] gpr_reg;
    logic [3:0][15:0] seg_reg;
    logic [15:0] flags_reg, data_reg, ea_reg;
    logic [2:0] idx_reg, popaIdx_reg;
    logic [1:0] kind_reg, segIdx_reg;
    logic wide_reg, rep_reg;
    logic memReq_reg, memWe_reg, memWide_reg, ioReq_reg, ioWide_reg;
    logic ready_reg, done_reg, illegal_reg;
    logic [15:0] memSeg_reg, memOff_reg, memWdata_reg, ioPort_reg, ioWdata_reg;

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    wire logic [15:0] sp = gpr_reg[spso_pkg::IDX_STACK];
    wire logic [15:0] si = gpr_reg[spso_pkg::IDX_SRC];
    wire logic [15:0] cx = gpr_reg[spso_pkg::IDX_COUNT];
    wire logic dirFlag = flags_reg[spso_pkg::FLAG_DIR_BIT];
    wire logic inIdle = state_reg == spso_pkg::ST_IDLE;
    wire logic take = inIdle & cmdValid;
    wire logic memDone = memReq_reg & memAck;
    wire logic ioDone = ioReq_reg & ioAck;
    wire logic isOuts = cmdOp == spso_pkg::OP_STRING_PORT_OUTPUT;
    wire logic isPush = cmdOp == spso_pkg::OP_PUSH;
    // Code segment may be pushed but never popped
    wire logic illegal = take & cmdOp == spso_pkg::OP_POP & cmdKind == spso_pkg::KIND_SEG
        & cmdIdx[1:0] == spso_pkg::SEG_CODE;
    wire logic repZero = take & isOuts & cmdRep & cx == spso_pkg::REG_RESET;
    wire logic pushNow = take & isPush & cmdKind != spso_pkg::KIND_MEM;
    wire logic [15:0] spDown = sp - spso_pkg::STACK_STEP;
    wire logic [15:0] spUp = sp + spso_pkg::STACK_STEP;
    // A pushed stack pointer shows its already lowered value
    wire logic [15:0] pushSrc = cmdKind == spso_pkg::KIND_SEG ? seg_reg[cmdIdx[1:0]]
        : (cmdIdx == spso_pkg::IDX_STACK ? spDown : gpr_reg[cmdIdx]);
    wire logic [15:0] step = wide_reg ? spso_pkg::STEP_WORD : spso_pkg::STEP_BYTE;
    wire logic [15:0] siNext = dirFlag ? si - step : si + step;
    wire logic [15:0] rdWord = memWide_reg ? memRdata : {8'h00, memRdata[7:0]};
    wire logic [1:0] effSeg = cmdSegOvr ? cmdSegSel : spso_pkg::SEG_DATA;
    wire logic inOutsRd = state_reg == spso_pkg::ST_STRING_PORT_OUTPUT_RD;
    wire logic inPopRd = state_reg == spso_pkg::ST_POP_RD;
    wire logic inPopaRd = state_reg == spso_pkg::ST_POP_ALL_REGS_RD;
    wire logic inPopfRd = state_reg == spso_pkg::ST_POP_FLAG_WORD_RD;
    wire logic inPushRd = state_reg == spso_pkg::ST_PUSH_RD;
    wire logic inMemWr = state_reg == spso_pkg::ST_POP_WR | state_reg == spso_pkg::ST_PUSH_WR;
    wire logic inMem = inOutsRd | inPopRd | inPopaRd | inPopfRd | inPushRd | inMemWr;
    wire logic useEa = inOutsRd | inPushRd | state_reg == spso_pkg::ST_POP_WR;
    wire logic spInc = memDone & (inPopRd | inPopaRd | inPopfRd);
    wire logic spDec = pushNow | (inPushRd & memDone);
    wire logic outsStep = state_reg == spso_pkg::ST_STRING_PORT_OUTPUT_WR & ioDone;
    wire logic loopOn = rep_reg & cx != spso_pkg::COUNT_STEP;

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            spso_pkg::ST_IDLE: begin
                if (take & !illegal & !repZero) begin
                    case (cmdOp)
                        spso_pkg::OP_STRING_PORT_OUTPUT: state_next = spso_pkg::ST_STRING_PORT_OUTPUT_RD;
                        spso_pkg::OP_POP: state_next = spso_pkg::ST_POP_RD;
                        spso_pkg::OP_POP_ALL_REGS: state_next = spso_pkg::ST_POP_ALL_REGS_RD;
                        spso_pkg::OP_POP_FLAG_WORD: state_next = spso_pkg::ST_POP_FLAG_WORD_RD;
                        spso_pkg::OP_PUSH: state_next = pushNow ? spso_pkg::ST_PUSH_WR
                            : spso_pkg::ST_PUSH_RD;
                        default: state_next = spso_pkg::ST_IDLE;
                    endcase
                end
            end
            spso_pkg::ST_STRING_PORT_OUTPUT_RD: if (memDone) state_next = spso_pkg::ST_STRING_PORT_OUTPUT_WR;
            spso_pkg::ST_STRING_PORT_OUTPUT_WR: begin
                if (ioDone) begin
                    state_next = loopOn ? spso_pkg::ST_STRING_PORT_OUTPUT_RD : spso_pkg::ST_IDLE;
                end
            end
            spso_pkg::ST_POP_RD: begin
                if (memDone) begin
                    state_next = kind_reg == spso_pkg::KIND_MEM ? spso_pkg::ST_POP_WR
                        : spso_pkg::ST_IDLE;
                end
            end
            spso_pkg::ST_POP_ALL_REGS_RD: begin
                if (memDone & popaIdx_reg == spso_pkg::IDX_ACC) state_next = spso_pkg::ST_IDLE;
            end
            spso_pkg::ST_PUSH_RD: if (memDone) state_next = spso_pkg::ST_PUSH_WR;
            spso_pkg::ST_POP_WR, spso_pkg::ST_POP_FLAG_WORD_RD, spso_pkg::ST_PUSH_WR: begin
                if (memDone) state_next = spso_pkg::ST_IDLE;
            end
            default: state_next = spso_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_reg <= spso_pkg::ST_IDLE;
            ready_reg <= 1'b1;
            done_reg <= 1'b0;
            illegal_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            ready_reg <= state_next == spso_pkg::ST_IDLE;
            done_reg <= (!inIdle & state_next == spso_pkg::ST_IDLE) | illegal | repZero;
            illegal_reg <= illegal;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            idx_reg <= 3'h0;
            kind_reg <= 2'h0;
            segIdx_reg <= spso_pkg::SEG_DATA;
            wide_reg <= 1'b1;
            rep_reg <= 1'b0;
            ea_reg <= spso_pkg::REG_RESET;
            popaIdx_reg <= spso_pkg::IDX_LAST;
        end else if (take) begin
            idx_reg <= cmdIdx;
            kind_reg <= cmdKind;
            segIdx_reg <= effSeg;
            wide_reg <= cmdWide | !isOuts;
            rep_reg <= cmdRep & isOuts;
            ea_reg <= cmdEaOff;
            popaIdx_reg <= spso_pkg::IDX_LAST;
        end else if (inPopaRd & memDone) begin
            popaIdx_reg <= popaIdx_reg - 3'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            data_reg <= spso_pkg::REG_RESET;
        end else if (pushNow) begin
            data_reg <= pushSrc;
        end else if (memDone & !inMemWr) begin
            data_reg <= rdWord;
        end
    end

    // ------------------------------------------------------------------
    // Register files
    // ------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_gpr
            localparam logic [2:0] ID = 3'(gi);
            wire logic ldHit = ldValid & ldSel == {1'b0, ID};
            // Pop-all skips the stack slot, the stack pointer only steps
            wire logic popHit = memDone & ((inPopRd & kind_reg == spso_pkg::KIND_GPR
                & idx_reg == ID) | (inPopaRd & popaIdx_reg == ID
                & ID != spso_pkg::IDX_STACK));
            logic [15:0] nextVal;
            always_comb begin
                nextVal = gpr_reg[gi];
                if (ID == spso_pkg::IDX_STACK & spInc) nextVal = spUp;
                if (ID == spso_pkg::IDX_STACK & spDec) nextVal = spDown;
                if (ID == spso_pkg::IDX_SRC & outsStep) nextVal = siNext;
                if (ID == spso_pkg::IDX_COUNT & outsStep & rep_reg) begin
                    nextVal = cx - spso_pkg::COUNT_STEP;
                end
                // A popped stack pointer still takes the step after delivery
                if (popHit) begin
                    nextVal = ID == spso_pkg::IDX_STACK ? memRdata + spso_pkg::STACK_STEP
                        : memRdata;
                end
                if (ldHit) nextVal = ldData;
            end
            always_ff @(posedge clk) begin
                if (!rst_n) gpr_reg[gi] <= spso_pkg::REG_RESET;
                else gpr_reg[gi] <= nextVal;
            end
        end
        for (gi = 0; gi < 4; gi++) begin : g_seg
            localparam logic [1:0] SID = 2'(gi);
            wire logic ldHit = ldValid & ldSel == spso_pkg::LD_SEG_BASE + {2'b00, SID};
            wire logic popHit = memDone & inPopRd & kind_reg == spso_pkg::KIND_SEG
                & idx_reg[1:0] == SID;
            always_ff @(posedge clk) begin
                if (!rst_n) seg_reg[gi] <= spso_pkg::REG_RESET;
                else if (ldHit) seg_reg[gi] <= ldData;
                else if (popHit) seg_reg[gi] <= memRdata;
            end
        end
    endgenerate

    // Only pop-flags and the load port touch the flags
    always_ff @(posedge clk) begin
        if (!rst_n) flags_reg <= spso_pkg::FLAGS_RESET;
        else if (ldValid & ldSel == spso_pkg::LD_FLAGS) flags_reg <= ldData & spso_pkg::FLAG_MASK;
        else if (inPopfRd & memDone) flags_reg <= memRdata & spso_pkg::FLAG_MASK;
    end

    // ------------------------------------------------------------------
    // Bus requests, held until acknowledged, one idle cycle between
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            memReq_reg <= 1'b0;
            memWe_reg <= 1'b0;
            memWide_reg <= 1'b1;
            memSeg_reg <= spso_pkg::REG_RESET;
            memOff_reg <= spso_pkg::REG_RESET;
            memWdata_reg <= spso_pkg::REG_RESET;
            ioReq_reg <= 1'b0;
            ioWide_reg <= 1'b1;
            ioPort_reg <= spso_pkg::REG_RESET;
            ioWdata_reg <= spso_pkg::REG_RESET;
        end else begin
            memReq_reg <= inMem & !memDone;
            memWe_reg <= inMem & inMemWr;
            memWide_reg <= !inOutsRd | wide_reg;
            memSeg_reg <= useEa ? seg_reg[segIdx_reg] : seg_reg[spso_pkg::SEG_STACK];
            memOff_reg <= inOutsRd ? si : (useEa ? ea_reg : sp);
            memWdata_reg <= data_reg;
            ioReq_reg <= state_reg == spso_pkg::ST_STRING_PORT_OUTPUT_WR & !ioDone;
            ioWide_reg <= wide_reg;
            ioPort_reg <= gpr_reg[spso_pkg::IDX_PORT];
            ioWdata_reg <= data_reg;
        end
    end

    assign cmdReady = ready_reg;
    assign cmdDone = done_reg;
    assign cmdIllegal = illegal_reg;
    assign memReq = memReq_reg;
    assign memWe = memWe_reg;
    assign memWide = memWide_reg;
    assign memSeg = memSeg_reg;
    assign memOff = memOff_reg;
    assign memWdata = memWdata_reg;
    assign ioReq = ioReq_reg;
    assign ioWide = ioWide_reg;
    assign ioPort = ioPort_reg;
    assign ioWdata = ioWdata_reg;
    assign gprBank = gpr_reg;
    assign segBank = seg_reg;
    assign flagWord = flags_reg;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_string_port_output_port: assert property (ioReq |-> ioPort == gpr_reg[spso_pkg::IDX_PORT]
        && memWdata == ioWdata) else $error("port output not from port register");
    a_string_port_output_seg: assert property (memReq && inOutsRd && !rep_reg
        |-> memOff == si && memSeg == seg_reg[segIdx_reg]) else $error("string source wrong");
    a_si_dir: assert property (outsStep && !ldValid |=> si == $past(siNext))
        else $error("source index step wrong");
    a_si_size: assert property (outsStep && wide_reg && !dirFlag && !ldValid
        |=> si == $past(si) + 16'h0002) else $error("word step not two");
    a_rep_zero: assert property (repZero |=> cmdDone && inIdle ##1 !memReq)
        else $error("zero count transfer performed");
    a_rep_count: assert property (outsStep && rep_reg && !ldValid
        |=> cx == $past(cx) - 16'h0001) else $error("count not decremented");
    a_pop_sp: assert property (inPopRd && memDone && kind_reg != spso_pkg::KIND_GPR
        && !ldValid |=> sp == $past(sp) + 16'h0002) else $error("pop stack step wrong");
    a_pop_code: assert property (illegal |=> cmdIllegal && inIdle)
        else $error("code segment pop accepted");
    a_pop_all_regs_skip: assert property (inPopaRd && memDone && popaIdx_reg == spso_pkg::IDX_STACK
        && !ldValid |=> sp == $past(sp) + 16'h0002) else $error("stack slot not discarded");
    a_pop_all_regs_order: assert property (inPopaRd && memDone && popaIdx_reg != 3'h0
        |=> popaIdx_reg == $past(popaIdx_reg) - 3'h1) else $error("pop-all order wrong");
    a_pop_flag_word_load: assert property (inPopfRd && memDone && !ldValid
        |=> flags_reg == ($past(memRdata) & spso_pkg::FLAG_MASK)) else $error("flags not popped");
    a_push_addr: assert property (memReq && state_reg == spso_pkg::ST_PUSH_WR
        |-> memWe && memOff == sp) else $error("push address wrong");
    a_flags_hold: assert property (!(inPopfRd && memDone) && !ldValid
        |=> $stable(flags_reg)) else $error("flags changed");

    c_rep_loop: cover property (outsStep && loopOn);
    c_pop_all_regs_end: cover property (inPopaRd && memDone && popaIdx_reg == 3'h0);
    c_push_mem: cover property (inPushRd && memDone);
    c_pop_mem: cover property (state_reg == spso_pkg::ST_POP_WR && memDone);
endmodule : spso_exec
`default_nettype wire

//--- spso_pkg.sv
// Shared constants and types for the stack and port string execution block
package spso_pkg;
    // ------------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [8:0] {
        ST_IDLE    = 9'h001,
        ST_STRING_PORT_OUTPUT_RD = 9'h002,
        ST_STRING_PORT_OUTPUT_WR = 9'h004,
        ST_POP_RD  = 9'h008,
        ST_POP_WR  = 9'h010,
        ST_POP_ALL_REGS_RD = 9'h020,
        ST_POP_FLAG_WORD_RD = 9'h040,
        ST_PUSH_RD = 9'h080,
        ST_PUSH_WR = 9'h100
    } spso_state_e;

    // ------------------------------------------------------------------
    // Commands and operand kinds
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_STRING_PORT_OUTPUT = 3'h0,
        OP_POP                = 3'h1,
        OP_POP_ALL_REGS       = 3'h2,
        OP_POP_FLAG_WORD      = 3'h3,
        OP_PUSH               = 3'h4
    } spso_op_e;

    typedef enum logic [1:0] {
        KIND_GPR = 2'h0,
        KIND_SEG = 2'h1,
        KIND_MEM = 2'h2
    } spso_kind_e;

    // ------------------------------------------------------------------
    // Register indices (pop-all loads them in reverse index order)
    // ------------------------------------------------------------------
    localparam logic [2:0] IDX_ACC = 3'h0;
    localparam logic [2:0] IDX_COUNT = 3'h1;
    localparam logic [2:0] IDX_PORT = 3'h2;
    localparam logic [2:0] IDX_STACK = 3'h4;
    localparam logic [2:0] IDX_SRC = 3'h6;
    localparam logic [2:0] IDX_LAST = 3'h7;
    localparam logic [1:0] SEG_CODE = 2'h1;
    localparam logic [1:0] SEG_STACK = 2'h2;
    localparam logic [1:0] SEG_DATA = 2'h3;

    // ------------------------------------------------------------------
    // Load port selectors, flags, steps and reset values
    // ------------------------------------------------------------------
    localparam logic [3:0] LD_SEG_BASE = 4'h8;
    localparam logic [3:0] LD_FLAGS = 4'hc;
    localparam int FLAG_DIR_BIT = 10;
    localparam logic [15:0] FLAG_MASK = 16'h0fd5;
    localparam logic [15:0] STEP_BYTE = 16'h0001;
    localparam logic [15:0] STEP_WORD = 16'h0002;
    localparam logic [15:0] STACK_STEP = 16'h0002;
    localparam logic [15:0] COUNT_STEP = 16'h0001;
    localparam logic [15:0] REG_RESET = 16'h0000;
    localparam logic [15:0] FLAGS_RESET = 16'h0000;
endpackage : spso_pkg

//--- testbench.sv
// Self-checking testbench for the execution block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk, rst_n, cmdValid, cmdWide, cmdRep, cmdSegOvr, ldValid, memAck, ioAck;
    logic [2:0] cmdOp, cmdIdx;
    logic [1:0] cmdSegSel, cmdKind, ackDelay;
    logic [15:0] cmdEaOff, ldData, memRdata, memSeg, memOff, memWdata, ioPort, ioWdata, flagWord;
    logic [3:0] ldSel;
    logic cmdReady, cmdDone, cmdIllegal, memReq, memWe, memWide, ioReq, ioWide, ill;
    logic [127:0] gprBank;
    logic [63:0] segBank;
    int err_count = 0;
    int cmp_count = 0;
    int k;
    spso_exec i_dut (.clk(clk), .rst_n(rst_n), .cmdValid(cmdValid), .cmdOp(cmdOp),
        .cmdWide(cmdWide), .cmdRep(cmdRep), .cmdSegOvr(cmdSegOvr), .cmdSegSel(cmdSegSel),
        .cmdKind(cmdKind), .cmdIdx(cmdIdx), .cmdEaOff(cmdEaOff), .ldValid(ldValid),
        .ldSel(ldSel), .ldData(ldData), .memAck(memAck), .memRdata(memRdata), .ioAck(ioAck),
        .cmdReady(cmdReady), .cmdDone(cmdDone), .cmdIllegal(cmdIllegal), .memReq(memReq),
        .memWe(memWe), .memWide(memWide), .memSeg(memSeg), .memOff(memOff),
        .memWdata(memWdata), .ioReq(ioReq), .ioWide(ioWide), .ioPort(ioPort),
        .ioWdata(ioWdata), .gprBank(gprBank), .segBank(segBank), .flagWord(flagWord));
    spso_bus_model i_bus (.clk(clk), .rst_n(rst_n), .ackDelay(ackDelay), .memReq(memReq),
        .memWe(memWe), .memWide(memWide), .memSeg(memSeg), .memOff(memOff),
        .memWdata(memWdata), .ioReq(ioReq), .ioPort(ioPort), .ioWdata(ioWdata),
        .memAck(memAck), .memRdata(memRdata), .ioAck(ioAck));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk
    function automatic logic [15:0] gpr(input int i);
        return gprBank[i*16 +: 16];
    endfunction : gpr
    function automatic logic [15:0] word(input logic [7:0] a);
        return {i_bus.mem[a + 8'h01], i_bus.mem[a]};
    endfunction : word
    task automatic poke(input logic [7:0] a, input logic [15:0] w);
        i_bus.mem[a] = w[7:0];
        i_bus.mem[a + 8'h01] = w[15:8];
    endtask : poke
    task automatic ld(input logic [3:0] sel, input logic [15:0] d);
        @(negedge clk);
        ldSel = sel;
        ldData = d;
        ldValid = 1'b1;
        @(negedge clk);
        ldValid = 1'b0;
    endtask : ld
    task automatic run(input logic [2:0] op, input logic wide, input logic rep,
        input logic ovr, input logic [1:0] seg, input logic [1:0] kind,
        input logic [2:0] idx, input logic [15:0] ea);
        int n;
        @(negedge clk);
        {cmdOp, cmdWide, cmdRep, cmdSegOvr, cmdSegSel} = {op, wide, rep, ovr, seg};
        {cmdKind, cmdIdx, cmdEaOff, cmdValid} = {kind, idx, ea, 1'b1};
        @(negedge clk);
        cmdValid = 1'b0;
        for (n = 0; n < 200 && cmdDone !== 1'b1; n++) @(negedge clk);
        ill = cmdIllegal;
        if (n == 200) begin
            err_count++;
            $display("[FAIL] %0t command never finished", $time);
            end_of_test();
        end
        chk(16'(cmdReady), 16'h0001, "ready at done");
    endtask : run
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic test_string_port_output();
        ld(4'h6, 16'h0010); ld(4'h2, 16'h0300); ld(4'hc, 16'h00d5);
        poke(8'h10, 16'ha55a);
        run(spso_pkg::OP_STRING_PORT_OUTPUT, 1'b0, 1'b0, 1'b0, 2'h0, 2'h0, 3'h0, 16'h0000);
        chk(i_bus.lastIo & 16'h00ff, 16'h005a, "byte out data");
        chk(i_bus.lastPort, 16'h0300, "port");
        chk(16'(ioWide), 16'h0000, "byte port width");
        chk(i_bus.lastSeg, 16'h1230, "default segment");
        chk(gpr(6), 16'h0011, "index byte up");
        chk(flagWord, 16'h00d5, "flags kept");
        ld(4'hc, 16'h04d5); ld(4'h6, 16'h0020); poke(8'h20, 16'hc33c);
        run(spso_pkg::OP_STRING_PORT_OUTPUT, 1'b1, 1'b0, 1'b1, 2'h0, 2'h0, 3'h0, 16'h0000);
        chk(i_bus.lastIo, 16'hc33c, "word out data");
        chk(i_bus.lastSeg, 16'h4560, "override segment");
        chk(gpr(6), 16'h001e, "index word down");
        chk(flagWord, 16'h04d5, "flags kept");
        $display("test_string_port_output done");
    endtask : test_string_port_output
    task automatic test_rep();
        int c0;
        ackDelay = 2'h2;
        ld(4'hc, 16'h0000); ld(4'h6, 16'h0030); ld(4'h1, 16'h0003);
        for (k = 0; k < 3; k++) poke(8'h30 + 8'(2*k), 16'h7100 + 16'(k));
        c0 = i_bus.ioCount;
        run(spso_pkg::OP_STRING_PORT_OUTPUT, 1'b1, 1'b1, 1'b0, 2'h0, 2'h0, 3'h0, 16'h0000);
        chk(16'(i_bus.ioCount - c0), 16'h0003, "repeat transfers");
        chk(gpr(1), 16'h0000, "count drained");
        chk(gpr(6), 16'h0036, "index after repeat");
        chk(i_bus.lastIo, 16'h7102, "last repeat word");
        run(spso_pkg::OP_STRING_PORT_OUTPUT, 1'b1, 1'b1, 1'b0, 2'h0, 2'h0, 3'h0, 16'h0000);
        chk(16'(i_bus.ioCount - c0), 16'h0003, "zero count no transfer");
        chk(gpr(6), 16'h0036, "index kept at zero count");
        ackDelay = 2'h0;
        $display("test_rep done");
    endtask : test_rep
    task automatic test_stack();
        ld(4'h4, 16'h0040); ld(4'h0, 16'hbeef); ld(4'h9, 16'h9990); ld(4'hc, 16'h0011);
        run(spso_pkg::OP_PUSH, 1'b1, 1'b0, 1'b0, 2'h0, spso_pkg::KIND_GPR, 3'h0, 16'h0000);
        chk(gpr(4), 16'h003e, "push stack step");
        chk(word(8'h3e), 16'hbeef, "push word order");
        chk(i_bus.lastSeg, 16'h7700, "stack segment");
        run(spso_pkg::OP_PUSH, 1'b1, 1'b0, 1'b0, 2'h0, spso_pkg::KIND_SEG, 3'h1, 16'h0000);
        chk(16'(ill), 16'h0000, "code push legal");
        chk(word(8'h3c), 16'h9990, "code push value");
        run(spso_pkg::OP_POP, 1'b1, 1'b0, 1'b0, 2'h0, spso_pkg::KIND_GPR, 3'h3, 16'h0000);
        chk(gpr(3), 16'h9990, "pop to register");
        chk(gpr(4), 16'h003e, "pop stack step");
        run(spso_pkg::OP_POP, 1'b1, 1'b0, 1'b0, 2'h0, spso_pkg::KIND_SEG, 3'h1, 16'h0000);
        chk(16'(ill), 16'h0001, "code pop illegal");
        chk(gpr(4), 16'h003e, "illegal pop keeps stack");
        run(spso_pkg::OP_POP, 1'b1, 1'b0, 1'b0, 2'h0, spso_pkg::KIND_MEM, 3'h0, 16'h0080);
        chk(word(8'h80), 16'hbeef, "pop to memory");
        chk(gpr(4), 16'h0040, "pop memory step");
        poke(8'h82, 16'h6d6d);
        run(spso_pkg::OP_PUSH, 1'b1, 1'b0, 1'b0, 2'h0, spso_pkg::KIND_MEM, 3'h0, 16'h0082);
        chk(word(8'h3e), 16'h6d6d, "push from memory");
        run(spso_pkg::OP_POP, 1'b1, 1'b0, 1'b0, 2'h0, spso_pkg::KIND_SEG, 3'h0, 16'h0000);
        chk(segBank[15:0], 16'h6d6d, "pop to segment");
        chk(gpr(4), 16'h0040, "pop segment step");
        chk(flagWord, 16'h0011, "flags kept");
        $display("test_stack done");
    endtask : test_stack
    task automatic test_pop_all_regs();
        ld(4'h4, 16'h0050);
        for (k = 0; k < 8; k++) poke(8'h50 + 8'(2*k), 16'h1100 + 16'(k));
        run(spso_pkg::OP_POP_ALL_REGS, 1'b1, 1'b0, 1'b0, 2'h0, 2'h0, 3'h0, 16'h0000);
        for (k = 0; k < 8; k++) begin
            if (k != 3) chk(gpr(7 - k), 16'h1100 + 16'(k), "pop-all register");
        end
        chk(gpr(4), 16'h0060, "pop-all stack slot discarded");
        chk(flagWord, 16'h0011, "flags kept");
        $display("test_pop_all_regs done");
    endtask : test_pop_all_regs
    task automatic test_pop_flag_word();
        ld(4'h4, 16'h0070); poke(8'h70, 16'hffff); poke(8'h72, 16'h0000);
        run(spso_pkg::OP_POP_FLAG_WORD, 1'b1, 1'b0, 1'b0, 2'h0, 2'h0, 3'h0, 16'h0000);
        chk(flagWord, spso_pkg::FLAG_MASK, "all flags set");
        chk(gpr(4), 16'h0072, "pop-flags stack step");
        run(spso_pkg::OP_POP_FLAG_WORD, 1'b1, 1'b0, 1'b0, 2'h0, 2'h0, 3'h0, 16'h0000);
        chk(flagWord, 16'h0000, "all flags replaced");
        $display("test_pop_flag_word done");
    endtask : test_pop_flag_word
    initial begin
        {rst_n, cmdValid, cmdWide, cmdRep, cmdSegOvr, ldValid} = 6'h00;
        {cmdOp, cmdIdx, cmdSegSel, cmdKind, ackDelay, ldSel} = 16'h0000;
        {cmdEaOff, ldData} = 32'h0000_0000;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        ld(4'hb, 16'h1230); ld(4'h8, 16'h4560); ld(4'ha, 16'h7700);
        test_string_port_output();
        test_rep();
        test_stack();
        test_pop_all_regs();
        test_pop_flag_word();
        end_of_test();
    end
endmodule : testbench
`default_nettype wire
